// ===== design/serial_error_flag_clear.sv
// serial error-flag clear block with AXI4-Lite register access
`timescale 1ns/100ps
module serial_error_flag_clear
  import sflag_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] err_fe_in,
  input wire logic [NCH-1:0] err_pe_in,
  input wire logic [NCH-1:0] err_ov_in,
  input wire logic async_receive_pin,
  output logic rx_pin_sync,
  output logic rx_active,
  output logic port_pin_free,
  output logic irq
);
  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire aw_take = s_axi_awvalid && !aw_full_q && !bvalid_q;
  wire w_take = s_axi_wvalid && !w_full_q && !bvalid_q;
  wire wr_fire = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire [7:0] wa = {aw_addr_q[7:2], 2'b00};
  wire lo_lane = w_strb_q[0];
  wire hi_lane = w_strb_q[1];
  wire is_clr_word = (wa < OFF_STATUS_BASE) && (wa[4:2] < 3'(NCH));
  wire is_alias = (wa >= OFF_LOW_ALIAS) && (wa < OFF_LOW_ALIAS + 8'(4 * NCH));
  wire is_status = (wa >= OFF_STATUS_BASE) && (wa < OFF_STATUS_BASE + 8'(4 * NCH));
  wire [2:0] w_idx = is_alias ? 3'(wa[4:2]) : 3'(wa[4:2]);
  wire wr_start = wr_fire && (wa == OFF_START) && lo_lane;
  wire wr_stop = wr_fire && (wa == OFF_STOP) && lo_lane;
  wire wr_mode = wr_fire && (wa == OFF_CH1_MODE) && lo_lane;
  wire wr_pin = wr_fire && (wa == OFF_PIN_CTRL) && lo_lane;
  wire wr_istat = wr_fire && (wa == OFF_IRQ_STATUS) && lo_lane;
  wire wr_imask = wr_fire && (wa == OFF_IRQ_MASK) && lo_lane;
  // the low byte alias and a full 16-bit word write both reach the trigger
  wire wr_clr_any = wr_fire && lo_lane && (is_clr_word || is_alias);
  wire wr_known = is_clr_word || is_alias || is_status || (wa == OFF_ENABLE) ||
                  (wa == OFF_START) || (wa == OFF_STOP) || (wa == OFF_CH1_MODE) ||
                  (wa == OFF_PIN_CTRL) || (wa == OFF_IRQ_STATUS) || (wa == OFF_IRQ_MASK);
  // bits 15..3 are ignored whatever software writes into them
  wire [2:0] clr_bits = w_data_q[2:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // trigger, status flags and receive-error capture per channel
  // ---------------------------------------------------------------
  logic [NCH-1:0][2:0] trig_q;
  err_flags_t [NCH-1:0] flag_q;
  logic [NCH-1:0] err_event;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire sel = wr_clr_any && (w_idx == 3'(g));
      wire [2:0] trig_now = sel ? clr_bits : 3'b000;
      wire [2:0] pending = trig_q[g] | trig_now;
      // a detected error sets its flag over a clear in the same cycle, but a flag that was already set is cleared one edge later by the held trigger
      wire fe_d = err_fe_in[g] | (flag_q[g].fe & ~pending[BIT_FEC]);
      wire pe_d = err_pe_in[g] | (flag_q[g].pe & ~pending[BIT_PEC]);
      wire ov_d = err_ov_in[g] | (flag_q[g].ov & ~pending[BIT_OVC]);
      assign err_event[g] = err_fe_in[g] | err_pe_in[g] | err_ov_in[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          trig_q[g] <= CLR_RESET[2:0];
          flag_q[g] <= '0;
        end else begin
          // the trigger is held one cycle past the clearing edge for flags that were set, then drops
          trig_q[g] <= trig_now & {flag_q[g].fe, flag_q[g].pe, flag_q[g].ov};
          flag_q[g] <= '{fe: fe_d, pe: pe_d, ov: ov_d};
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // channel enable, channel 1 mode and pin control
  // ---------------------------------------------------------------
  logic [NCH-1:0] enable_q;
  ch_mode_t ch1_mode_q;
  logic pin_dir_q;
  logic pin_latch_q;
  logic [NCH-1:0] irq_stat_q;
  logic [NCH-1:0] irq_mask_q;

  // start and stop are one-shot masks; only a written one moves an enable bit
  wire [NCH-1:0] start_set = wr_start ? w_data_q[NCH-1:0] : '0;
  wire [NCH-1:0] stop_clr = wr_stop ? w_data_q[NCH-1:0] : '0;
  wire [NCH-1:0] istat_clr = wr_istat ? w_data_q[NCH-1:0] : '0;

  // enable only moves through start and stop writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= '0;
    end else begin
      enable_q <= (enable_q | start_set) & ~stop_clr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch1_mode_q <= '0;
    end else if (wr_mode) begin
      ch1_mode_q <= w_data_q[3:0];
    end
  end

  // direction and latch are kept even while the port owns the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_dir_q <= 1'b0;
      pin_latch_q <= 1'b0;
    end else if (wr_pin) begin
      pin_dir_q <= w_data_q[0];
      pin_latch_q <= w_data_q[1];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // an error in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= err_event | (irq_stat_q & ~istat_clr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= '0;
    end else if (wr_imask) begin
      irq_mask_q <= w_data_q[NCH-1:0];
    end
  end

  // async reception needs enable, mode 01, rx on, tx off, pin as input
  wire rx_cfg_ok = enable_q[1] && (ch1_mode_q.mode == MODE_ASYNC) && !ch1_mode_q.tx_en &&
                   ch1_mode_q.rx_en && pin_dir_q;

  // ---------------------------------------------------------------
  // receive pin synchroniser and outputs
  // ---------------------------------------------------------------
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_active_q;
  logic port_free_q;
  logic irq_q;

  // reset to the idle line level so no false start bit follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= async_receive_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_active_q <= 1'b0;
      port_free_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      rx_active_q <= rx_cfg_ok;
      // stopped channel 1 hands the pin back to the port
      port_free_q <= !enable_q[1];
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [2:0] r_idx = 3'(ra[4:2]);
  wire r_is_clr = ((ra < OFF_STATUS_BASE) && (r_idx < 3'(NCH))) ||
                  ((ra >= OFF_LOW_ALIAS) && (ra < OFF_LOW_ALIAS + 8'(4 * NCH)));
  wire r_is_stat = (ra >= OFF_STATUS_BASE) && (ra < OFF_STATUS_BASE + 8'(4 * NCH));
  wire [31:0] stat_word = {29'h0000_0000, flag_q[r_idx]};
  wire sel_enable = (ra == OFF_ENABLE);
  wire sel_start = (ra == OFF_START);
  wire sel_stop = (ra == OFF_STOP);
  wire sel_mode = (ra == OFF_CH1_MODE);
  wire sel_pin = (ra == OFF_PIN_CTRL);
  wire sel_istat = (ra == OFF_IRQ_STATUS);
  wire sel_imask = (ra == OFF_IRQ_MASK);

  // ---------------------------------------------------------------
  // read data words
  // ---------------------------------------------------------------
  wire [31:0] enable_word = {26'h000_0000, enable_q};
  wire [31:0] mode_word = {28'h000_0000, ch1_mode_q};
  wire [31:0] pin_word = {30'h0000_0000, pin_latch_q, pin_dir_q};
  wire [31:0] istat_word = {26'h000_0000, irq_stat_q};
  wire [31:0] imask_word = {26'h000_0000, irq_mask_q};

  // selects are one-hot, so an and-or mux stays flat; start and stop read zero
  wire [31:0] rd_mux =
      r_is_clr ? ZERO32 :
      ({32{r_is_stat}} & stat_word) | ({32{sel_enable}} & enable_word) |
      ({32{sel_mode}} & mode_word) | ({32{sel_pin}} & pin_word) |
      ({32{sel_istat}} & istat_word) | ({32{sel_imask}} & imask_word);
  wire rd_known = r_is_clr || r_is_stat || sel_enable || sel_start || sel_stop ||
                  sel_mode || sel_pin || sel_istat || sel_imask;
  wire ar_take = s_axi_arvalid && arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= ZERO32;
      rresp_q <= AXI_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_known ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rx_pin_sync = rx_sync_q;
  assign rx_active = rx_active_q;
  assign port_pin_free = port_free_q;
  assign irq = irq_q;
  // hi_lane is accepted but carries only always-zero bits
  wire unused_ok = hi_lane;
endmodule

// ===== shared/sflag_pkg.sv
// package: register map, field layout and types of the serial error-flag clear block
package sflag_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CLR_CH00 = 8'h00;
  localparam logic [7:0] OFF_CLR_CH01 = 8'h04;
  localparam logic [7:0] OFF_CLR_CH02 = 8'h08;
  localparam logic [7:0] OFF_CLR_CH03 = 8'h0c;
  localparam logic [7:0] OFF_CLR_CH12 = 8'h10;
  localparam logic [7:0] OFF_CLR_CH13 = 8'h14;
  localparam logic [7:0] OFF_STATUS_BASE = 8'h20;
  localparam logic [7:0] OFF_ENABLE = 8'h40;
  localparam logic [7:0] OFF_START = 8'h44;
  localparam logic [7:0] OFF_STOP = 8'h48;
  localparam logic [7:0] OFF_CH1_MODE = 8'h4c;
  localparam logic [7:0] OFF_PIN_CTRL = 8'h50;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h54;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h58;
  localparam logic [7:0] OFF_LOW_ALIAS = 8'h60;
  // ---------------------------------------------------------------
  // fields and sizes
  // ---------------------------------------------------------------
  localparam int NCH = 6;
  localparam int BIT_OVC = 0;
  localparam int BIT_PEC = 1;
  localparam int BIT_FEC = 2;
  localparam logic [15:0] CLR_RESET = 16'h0000;
  localparam logic [1:0] MODE_ASYNC = 2'b01;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef struct packed {
    logic fe;
    logic pe;
    logic ov;
  } err_flags_t;

  typedef struct packed {
    logic [1:0] mode;
    logic tx_en;
    logic rx_en;
  } ch_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BUSY = 2'b01
  } rx_state_t;
endpackage

// ===== tb/rx_line_model.sv
// behavioural serial transmitter driving the block's receive pin
`timescale 1ns/100ps
module rx_line_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] data,
  output logic line
);
  logic [9:0] frame;
  // idles high so the receiver never sees a false start bit
  initial line = 1'b1;
  always @(posedge clk) begin
    if (go) begin
      frame = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++) begin
        line <= frame[i];
        repeat (BIT_CYC) @(posedge clk);
      end
    end
  end
endmodule

// ===== tb/serial_error_flag_clear_test.sv
// self-checking bench for the serial error-flag clear block
`timescale 1ns/100ps
module serial_error_flag_clear_test;
  import sflag_pkg::*;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [7:0] sa;
    logic [31:0] ex;
  } row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
  logic [5:0] err_fe_in = 6'h00, err_pe_in = 6'h00, err_ov_in = 6'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b;
  logic [31:0] s_axi_rdata, rd_d;
  logic rx_pin_sync, rx_active, port_pin_free, irq;
  wire logic async_receive_pin;
  int error_cnt = 0;
  int tests_run = 0;
  // alias row uses only the low strobe; last row lacks it and must change nothing
  row_t rows [7] = '{'{8'h00, 32'h4, 4'hf, 8'h20, 32'h3}, '{8'h00, 32'h0, 4'hf, 8'h20, 32'h3},
    '{8'h04, 32'h2, 4'hf, 8'h24, 32'h5}, '{8'h08, 32'h1, 4'hf, 8'h28, 32'h6},
    '{8'h0c, 32'h7, 4'hf, 8'h2c, 32'h0}, '{8'h70, 32'h7, 4'h1, 8'h30, 32'h0},
    '{8'h14, 32'h7, 4'h2, 8'h34, 32'h7}};
  always #5 aclk = ~aclk;
  serial_error_flag_clear dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .err_fe_in, .err_pe_in, .err_ov_in, .async_receive_pin,
    .rx_pin_sync, .rx_active, .port_pin_free, .irq);
  rx_line_model #(.BIT_CYC(4)) u_line (.clk(aclk), .go(go), .data(8'h5a),
    .line(async_receive_pin));
  // ------------------------------------------------------------
  // bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask
  task automatic pulse(input logic [5:0] fe, input logic [5:0] pe, input logic [5:0] ov);
    @(posedge aclk);
    err_fe_in <= fe;
    err_pe_in <= pe;
    err_ov_in <= ov;
    @(posedge aclk);
    {err_fe_in, err_pe_in, err_ov_in} <= 18'h0;
  endtask
  task automatic end_of_test();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NCH; i++) rchk(8'(4 * i), 32'h0);
    pulse(6'h3f, 6'h3f, 6'h3f);
    for (int i = 0; i < NCH; i++) rchk(OFF_STATUS_BASE + 8'(4 * i), 32'h7);
    chk({31'h0, irq}, 32'h0);
    // row data keep bits 15..3 at zero
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd, rows[i].ws);
      chk({30'h0, wr_b}, {30'h0, AXI_OKAY});
      rchk(rows[i].sa, rows[i].ex);
    end
    for (int i = 0; i < NCH; i++) rchk(8'(4 * i), 32'h0);
    pulse(6'h01, 6'h00, 6'h00);
    rchk(OFF_STATUS_BASE, 32'h7);
    wr(OFF_IRQ_MASK, 32'h3f, 4'hf);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h3f, 4'hf);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h7c);
    chk({30'h0, rd_r}, {30'h0, AXI_SLVERR});
    wr(8'h7c, 32'h1, 4'hf);
    chk({30'h0, wr_b}, {30'h0, AXI_SLVERR});
    wr(OFF_ENABLE, 32'h2, 4'hf);
    rchk(OFF_ENABLE, 32'h0);
    wr(OFF_START, 32'h2, 4'hf);
    repeat (4) @(posedge aclk);
    wr(OFF_CH1_MODE, 32'h5, 4'hf);
    wr(OFF_PIN_CTRL, 32'h1, 4'hf);
    rchk(OFF_ENABLE, 32'h2);
    chk({30'h0, rx_active, port_pin_free}, 32'h2);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (48) @(posedge aclk);
    // channel 1 back to stop mode before the pin is reused
    wr(OFF_STOP, 32'h2, 4'hf);
    repeat (2) @(posedge aclk);
    chk({30'h0, rx_active, port_pin_free}, 32'h1);
    chk({31'h0, rx_pin_sync}, 32'h1);
    end_of_test();
  end
endmodule

// ===== tb/serial_flag_sva.sv
// assertion checker for the serial error-flag clear block
`timescale 1ns/100ps
module serial_flag_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic async_receive_pin,
  input wire logic rx_pin_sync,
  input wire logic rx_active,
  input wire logic port_pin_free,
  input wire logic irq
);
  logic [7:0] ar_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // read address in flight, needed to judge the returned data
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_reset_idle;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && port_pin_free && !rx_active;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_read_zero;
    s_axi_rvalid && ar_q < 8'h18 |-> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("trigger read not zero");
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_answer;
    s_wr_taken |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
  property p_pin_sync;
    rx_pin_sync == $past(async_receive_pin, 2);
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("receive pin not followed");
  property p_rx_excl;
    rx_active |-> !port_pin_free;
  endproperty
  a_rx_excl: assert property (p_rx_excl) else $error("pin free while receiving");
endmodule

bind serial_error_flag_clear serial_flag_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .async_receive_pin, .rx_pin_sync, .rx_active, .port_pin_free, .irq);
